// ### design/auxreg_pkg.sv
// Shared types and constants for the auxiliary regulator control block
package auxreg_pkg;

   // ****************************************
   // Operating modes of the chip
   // ****************************************
   typedef enum logic [2:0] {
      MODE_INIT,
      MODE_NORMAL,
      MODE_STOP,
      MODE_SLEEP,
      MODE_RESTART,
      MODE_FAILSAFE
   } auxreg_mode_e;

   typedef enum logic [1:0] {
      CFG_NONE,
      CFG_STANDALONE,
      CFG_SHARE
   } auxreg_cfg_e;

   // ****************************************
   // Register-write carrier
   // ****************************************
   typedef struct packed {
      logic enable;
      logic shareSelect;
      logic voltageSelect;
      logic stayOnInStop;
      logic stayOffAfterUv;
   } auxreg_ctrl_s;

   typedef struct packed {
      logic shuntOverThreshold;
      logic auxUnderVoltage;
      logic batteryUnderVoltage;
   } auxreg_sense_s;

   localparam logic RESET_ENABLE = 1'b0;
   localparam logic RESET_SHARE = 1'b0;
   localparam logic RESET_VSEL = 1'b0;
   localparam logic RESET_STAYON = 1'b0;
   localparam logic RESET_STAYOFF = 1'b0;
   localparam logic VSEL_3V3 = 1'b0;
   localparam int SYNC_STAGES = 3;

endpackage : auxreg_pkg

// ### design/auxreg_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module auxreg_sync
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic asyncIn,
   output logic syncOut
);
   logic [auxreg_pkg::SYNC_STAGES-1:0] stage_q;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         stage_q <= '0;
      else
         stage_q <= {stage_q[1:0], asyncIn};
   end

   // Change counts only once stages two and three agree
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         syncOut <= 1'b0;
      else if (stage_q[1] == stage_q[2])
         syncOut <= stage_q[2];
   end
endmodule : auxreg_sync

// ### design/auxreg_lock.sv
// One-time configuration lock held across soft reset
`timescale 1ns/1ps
module auxreg_lock
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic inNormal,
   input wire logic wrStrobe,
   input wire logic wrEnable,
   input wire logic wrShare,
   output auxreg_pkg::auxreg_cfg_e cfg,
   output logic changeRefused
);
   auxreg_pkg::auxreg_cfg_e cfg_q;
   logic attempt;

   // Attempt to leave the locked configuration
   always_comb
   begin
      attempt = 1'b0;
      unique case (cfg_q)
         auxreg_pkg::CFG_STANDALONE: attempt = wrStrobe && wrShare;
         auxreg_pkg::CFG_SHARE: attempt = wrStrobe && (wrEnable || !wrShare);
         default: attempt = 1'b0;
      endcase
   end

   // rstn here is power-on only, a soft reset does not reach it
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cfg_q <= auxreg_pkg::CFG_NONE;
      else if (cfg_q == auxreg_pkg::CFG_NONE && wrStrobe)
      begin
         if (wrShare)
            cfg_q <= auxreg_pkg::CFG_SHARE;
         else if (wrEnable && inNormal)
            cfg_q <= auxreg_pkg::CFG_STANDALONE;
      end
   end

   assign cfg = cfg_q;
   // Only the share configuration reports the refused change
   assign changeRefused = attempt && (cfg_q == auxreg_pkg::CFG_SHARE);

   stay_locked_a: assert property (@(posedge core_clk) disable iff (!rstn)
      cfg_q != auxreg_pkg::CFG_NONE |=> cfg_q == $past(cfg_q))
      else $error("configuration changed after lock");
endmodule : auxreg_lock

// ### design/auxreg_ctrl.sv
// Auxiliary regulator configuration and control
`timescale 1ns/1ps
module auxreg_ctrl
(
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic softResetn,
   input auxreg_pkg::auxreg_mode_e mode,
   input wire logic ctrlWrite,
   input auxreg_pkg::auxreg_ctrl_s ctrlData,
   input wire logic clearOvercurrent,
   input wire logic clearUndervoltage,
   input auxreg_pkg::auxreg_sense_s sensePins,
   output logic aux_supply_enable,
   output logic load_share_select,
   output logic aux_voltage_select,
   output logic share_stay_on_in_stop,
   output logic stay_off_after_undervoltage,
   output logic supplyOn,
   output logic currentLimitOn,
   output logic outputIs1v8,
   output logic aux_overcurrent_flag,
   output logic aux_undervoltage_flag,
   output logic spiFailSet,
   output auxreg_pkg::auxreg_cfg_e configuration
);
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic shuntHigh;
   logic auxUv;
   logic batUv;

   auxreg_sync u_syncShunt
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .asyncIn(sensePins.shuntOverThreshold),
      .syncOut(shuntHigh)
   );
   auxreg_sync u_syncAuxUv
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .asyncIn(sensePins.auxUnderVoltage),
      .syncOut(auxUv)
   );
   auxreg_sync u_syncBatUv
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .asyncIn(sensePins.batteryUnderVoltage),
      .syncOut(batUv)
   );

   // ****************************************
   // Configuration lock
   // ****************************************
   auxreg_pkg::auxreg_cfg_e cfg;
   logic refused;
   logic inNormal;
   logic standAlone;
   logic sharing;

   assign inNormal = (mode == auxreg_pkg::MODE_NORMAL);

   auxreg_lock u_lock
   (
      .core_clk(core_clk),
      .rstn(rstn),
      .inNormal(inNormal),
      .wrStrobe(ctrlWrite),
      .wrEnable(ctrlData.enable),
      .wrShare(ctrlData.shareSelect),
      .cfg(cfg),
      .changeRefused(refused)
   );

   assign standAlone = (cfg == auxreg_pkg::CFG_STANDALONE);
   assign sharing = (cfg == auxreg_pkg::CFG_SHARE);
   assign configuration = cfg;
   assign spiFailSet = refused;

   // ****************************************
   // Control bits, cleared by power-on reset; soft reset clears all but share select, which reloads from the share lock
   // ****************************************
   logic enable_q;
   logic share_q;
   logic vsel_q;
   logic stayOn_q;
   logic stayOff_q;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         enable_q <= auxreg_pkg::RESET_ENABLE;
         share_q <= auxreg_pkg::RESET_SHARE;
         vsel_q <= auxreg_pkg::RESET_VSEL;
         stayOn_q <= auxreg_pkg::RESET_STAYON;
         stayOff_q <= auxreg_pkg::RESET_STAYOFF;
      end
      else if (!softResetn)
      begin
         enable_q <= auxreg_pkg::RESET_ENABLE;
         share_q <= sharing;
         vsel_q <= auxreg_pkg::RESET_VSEL;
         stayOn_q <= auxreg_pkg::RESET_STAYON;
         stayOff_q <= auxreg_pkg::RESET_STAYOFF;
      end
      else if (ctrlWrite)
      begin
         // Enable has no effect once sharing is locked; share select is ignored once stand-alone
         if (standAlone)
            enable_q <= ctrlData.enable;
         else if (cfg == auxreg_pkg::CFG_NONE && inNormal && !ctrlData.shareSelect)
            enable_q <= ctrlData.enable;
         if (cfg == auxreg_pkg::CFG_NONE)
            share_q <= ctrlData.shareSelect;
         vsel_q <= ctrlData.voltageSelect;
         stayOn_q <= ctrlData.stayOnInStop;
         stayOff_q <= ctrlData.stayOffAfterUv;
      end
   end

   assign aux_supply_enable = enable_q;
   assign load_share_select = share_q;
   assign aux_voltage_select = vsel_q;
   assign share_stay_on_in_stop = stayOn_q;
   assign stay_off_after_undervoltage = stayOff_q;

   // ****************************************
   // Battery undervoltage latch-off
   // ****************************************
   logic uvOff_q;

   // Stay-off holds the supply down until software rewrites the enable
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         uvOff_q <= 1'b0;
      else if (batUv && stayOff_q)
         uvOff_q <= 1'b1;
      else if (ctrlWrite && ctrlData.enable)
         uvOff_q <= 1'b0;
   end

   // ****************************************
   // Supply state by mode
   // ****************************************
   logic modeAllows;

   always_comb
   begin
      modeAllows = 1'b0;
      if (sharing)
      begin
         unique case (mode)
            auxreg_pkg::MODE_NORMAL: modeAllows = 1'b1;
            auxreg_pkg::MODE_STOP: modeAllows = stayOn_q;
            auxreg_pkg::MODE_RESTART: modeAllows = 1'b1;
            auxreg_pkg::MODE_FAILSAFE: modeAllows = 1'b0;
            default: modeAllows = 1'b0;
         endcase
      end
      else if (standAlone)
      begin
         unique case (mode)
            auxreg_pkg::MODE_INIT: modeAllows = 1'b0;
            auxreg_pkg::MODE_FAILSAFE: modeAllows = 1'b0;
            default: modeAllows = enable_q;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         supplyOn <= 1'b0;
      else
         supplyOn <= modeAllows && !batUv && !uvOff_q;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         outputIs1v8 <= 1'b0;
      else
         outputIs1v8 <= standAlone && (vsel_q != auxreg_pkg::VSEL_3V3);
   end

   // ****************************************
   // Status flags, set wins over clear
   // ****************************************
   logic ocFlag_q;
   logic uvFlag_q;

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         currentLimitOn <= 1'b0;
      else
         currentLimitOn <= standAlone && supplyOn && shuntHigh;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         ocFlag_q <= 1'b0;
      else if (standAlone && supplyOn && shuntHigh)
         ocFlag_q <= 1'b1;
      else if (clearOvercurrent && !shuntHigh)
         ocFlag_q <= 1'b0;
   end

   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         uvFlag_q <= 1'b0;
      else if (standAlone && supplyOn && auxUv)
         uvFlag_q <= 1'b1;
      else if (clearUndervoltage)
         uvFlag_q <= 1'b0;
   end

   assign aux_overcurrent_flag = ocFlag_q;
   assign aux_undervoltage_flag = uvFlag_q;

   // ****************************************
   // Checks
   // ****************************************
   oc_never_share_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sharing |-> !ocFlag_q || $past(ocFlag_q))
      else $error("overcurrent flag rose in share mode");

   oc_clear_hold_a: assert property (@(posedge core_clk) disable iff (!rstn)
      ocFlag_q && shuntHigh |=> ocFlag_q)
      else $error("overcurrent cleared while condition present");

   oc_sticky_a: assert property (@(posedge core_clk) disable iff (!rstn)
      ocFlag_q && !clearOvercurrent |=> ocFlag_q)
      else $error("overcurrent flag dropped without clear");

   oc_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      standAlone && supplyOn && shuntHigh |=> ocFlag_q)
      else $error("overcurrent flag not set");

   uv_never_share_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sharing && !$past(uvFlag_q) |-> !uvFlag_q)
      else $error("undervoltage flag rose in share mode");

   uv_set_a: assert property (@(posedge core_clk) disable iff (!rstn)
      standAlone && supplyOn && auxUv |=> uvFlag_q)
      else $error("undervoltage flag not set");

   failsafe_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sharing && mode == auxreg_pkg::MODE_FAILSAFE |=> !supplyOn)
      else $error("supply on in fail-safe");

   stop_share_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sharing && mode == auxreg_pkg::MODE_STOP |=> supplyOn == ($past(stayOn_q) && !$past(batUv) && !$past(uvOff_q)))
      else $error("stop mode share state wrong");

   normal_share_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sharing && inNormal && !batUv && !uvOff_q |=> supplyOn)
      else $error("share not active in normal");

   bat_uv_off_a: assert property (@(posedge core_clk) disable iff (!rstn)
      batUv |=> !supplyOn)
      else $error("supply on during battery undervoltage");

   share_fail_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sharing && ctrlWrite && !ctrlData.shareSelect |-> spiFailSet)
      else $error("share change not reported");

   alone_quiet_a: assert property (@(posedge core_clk) disable iff (!rstn)
      standAlone |-> !spiFailSet)
      else $error("stand-alone change raised failure");

   share_enable_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sharing |-> !enable_q)
      else $error("enable taken in share mode");

   share_vsel_a: assert property (@(posedge core_clk) disable iff (!rstn)
      sharing |=> !outputIs1v8)
      else $error("voltage select used in share mode");
endmodule : auxreg_ctrl

// ### verification/auxreg_ctrl_tb_top.sv
// Self-checking testbench for the auxiliary regulator control block
`timescale 1ns/1ps
module auxreg_ctrl_tb_top;
   // ****************************************
   // Write fields, observed bits, signals
   // ****************************************
   localparam logic [4:0] wEn = 5'h10;
   localparam logic [4:0] wLs = 5'h08;
   localparam logic [4:0] wVs = 5'h04;
   localparam logic [4:0] wStay = 5'h02;
   localparam logic [4:0] wOff = 5'h01;
   localparam logic [12:0] bVsR = 13'h1000;
   localparam logic [12:0] bStR = 13'h0800;
   localparam logic [12:0] bOfR = 13'h0400;
   localparam logic [12:0] bOn = 13'h0080;
   localparam logic [12:0] bLim = 13'h0040;
   localparam logic [12:0] bV18 = 13'h0020;
   localparam logic [12:0] bOc = 13'h0010;
   localparam logic [12:0] bUv = 13'h0008;
   localparam logic [12:0] bFail = 13'h0004;
   localparam logic [12:0] bEn = 13'h0002;
   localparam logic [12:0] bLs = 13'h0001;
   localparam logic [12:0] cSa = {3'h0, auxreg_pkg::CFG_STANDALONE, 8'h00};
   localparam logic [12:0] cSh = {3'h0, auxreg_pkg::CFG_SHARE, 8'h00};
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic softResetn = 1'b1;
   logic ctrlWrite = 1'b0;
   logic clearOvercurrent = 1'b0;
   logic clearUndervoltage = 1'b0;
   auxreg_pkg::auxreg_mode_e mode = auxreg_pkg::MODE_INIT;
   auxreg_pkg::auxreg_ctrl_s ctrlData = 5'h00;
   auxreg_pkg::auxreg_sense_s sensePins = 3'h0;
   logic aux_supply_enable, load_share_select, aux_voltage_select, share_stay_on_in_stop;
   logic stay_off_after_undervoltage, supplyOn, currentLimitOn, outputIs1v8;
   logic aux_overcurrent_flag, aux_undervoltage_flag, spiFailSet;
   auxreg_pkg::auxreg_cfg_e configuration;
   int mismatches = 0;
   int compares = 0;
   logic [12:0] expQ[$];
   logic [31:0] rnd = 32'hc6db;
   logic [4:0] rndField = 5'h00;
   logic [12:0] rbPrev = 13'h0000;
   wire logic [12:0] seen = {aux_voltage_select, share_stay_on_in_stop, stay_off_after_undervoltage, configuration,
      supplyOn, currentLimitOn, outputIs1v8, aux_overcurrent_flag, aux_undervoltage_flag, spiFailSet,
      aux_supply_enable, load_share_select};

   always #12.5 core_clk = ~core_clk;

   auxreg_ctrl auxreg_ctrl_i (.core_clk(core_clk), .rstn(rstn), .softResetn(softResetn), .mode(mode),
      .ctrlWrite(ctrlWrite), .ctrlData(ctrlData), .clearOvercurrent(clearOvercurrent),
      .clearUndervoltage(clearUndervoltage), .sensePins(sensePins), .aux_supply_enable(aux_supply_enable),
      .load_share_select(load_share_select), .aux_voltage_select(aux_voltage_select),
      .share_stay_on_in_stop(share_stay_on_in_stop), .stay_off_after_undervoltage(stay_off_after_undervoltage),
      .supplyOn(supplyOn), .currentLimitOn(currentLimitOn), .outputIs1v8(outputIs1v8),
      .aux_overcurrent_flag(aux_overcurrent_flag), .aux_undervoltage_flag(aux_undervoltage_flag),
      .spiFailSet(spiFailSet), .configuration(configuration));

   // ****************************************
   // Tasks
   // ****************************************
   task automatic check(input logic [12:0] got, input logic [12:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic close_out();
      $display("Compared %0d, mismatched %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out

   task automatic step(input int n);
      repeat (n) @(negedge core_clk);
   endtask : step

   // Note is sampled at the next rising edge, before that edge's updates land
   task automatic look(input logic [12:0] e);
      expQ.push_back(e);
      @(negedge core_clk);
   endtask : look

   task automatic wr(input logic [4:0] d, input logic [12:0] e);
      ctrlData = d;
      ctrlWrite = 1'b1;
      look(e);
      ctrlWrite = 1'b0;
   endtask : wr

   task automatic clr(input logic oc);
      clearOvercurrent = oc;
      clearUndervoltage = !oc;
      step(1);
      clearOvercurrent = 1'b0;
      clearUndervoltage = 1'b0;
   endtask : clr

   // Stay-off bit only: voltage select and stay-on would change the supply state under test
   function automatic logic [4:0] randLow();
      rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      return rnd[4:0] & 5'h01;
   endfunction : randLow

   // ****************************************
   // Monitor
   // ****************************************
   always @(posedge core_clk)
   begin
      if (expQ.size() != 0)
         check(seen, expQ.pop_front());
   end

   initial
   begin
      #75000;
      mismatches++;
      close_out();
   end

   // ****************************************
   // Scenarios
   // ****************************************
   initial
   begin
      step(1);
      look(13'h0000);
      step(4);
      rstn = 1'b1;
      mode = auxreg_pkg::MODE_STOP;
      wr(wEn, 13'h0000);
      step(2);
      look(13'h0000);
      mode = auxreg_pkg::MODE_NORMAL;
      step(1);
      wr(wEn | wVs, 13'h0000);
      step(2);
      look(cSa | bEn | bOn | bV18 | bVsR);
      rndField = randLow();
      wr(wEn | wLs | wVs | rndField, cSa | bEn | bOn | bV18 | bVsR);
      rbPrev = rndField[0] ? bOfR : 13'h0000;
      step(2);
      look(cSa | bEn | bOn | bV18 | bVsR | rbPrev);
      wr(5'h00, cSa | bEn | bOn | bV18 | bVsR | rbPrev);
      step(2);
      look(cSa);
      wr(wEn, cSa);
      step(2);
      look(cSa | bEn | bOn);
      sensePins = 3'h4;
      step(8);
      look(cSa | bEn | bOn | bLim | bOc);
      clr(1'b1);
      step(2);
      look(cSa | bEn | bOn | bLim | bOc);
      sensePins = 3'h0;
      step(8);
      look(cSa | bEn | bOn | bOc);
      clr(1'b1);
      step(2);
      look(cSa | bEn | bOn);
      sensePins = 3'h2;
      step(8);
      look(cSa | bEn | bOn | bUv);
      sensePins = 3'h0;
      step(8);
      clr(1'b0);
      step(2);
      look(cSa | bEn | bOn);
      sensePins = 3'h1;
      step(8);
      look(cSa | bEn);
      sensePins = 3'h0;
      step(8);
      look(cSa | bEn | bOn);
      wr(wEn | wOff, cSa | bEn | bOn);
      sensePins = 3'h1;
      step(8);
      sensePins = 3'h0;
      step(8);
      look(cSa | bEn | bOfR);
      wr(wEn, cSa | bEn | bOfR);
      step(2);
      look(cSa | bEn | bOn);
      softResetn = 1'b0;
      step(2);
      softResetn = 1'b1;
      step(2);
      look(cSa);
      rstn = 1'b0;
      step(2);
      look(13'h0000);
      rstn = 1'b1;
      step(1);
      wr(wLs | wVs, 13'h0000);
      step(2);
      look(cSh | bLs | bOn | bVsR);
      rbPrev = bVsR;
      for (int i = 0; i < 4; i++)
      begin
         rndField = randLow();
         wr((i[0] ? (wEn | wLs) : 5'h00) | rndField, cSh | bLs | bOn | bFail | rbPrev);
         rbPrev = rndField[0] ? bOfR : 13'h0000;
         step(1);
      end
      step(1);
      look(cSh | bLs | bOn | rbPrev);
      mode = auxreg_pkg::MODE_STOP;
      step(4);
      look(cSh | bLs | rbPrev);
      mode = auxreg_pkg::MODE_NORMAL;
      step(4);
      look(cSh | bLs | bOn | rbPrev);
      wr(wLs | wStay, cSh | bLs | bOn | rbPrev);
      mode = auxreg_pkg::MODE_STOP;
      step(4);
      look(cSh | bLs | bOn | bStR);
      sensePins = 3'h6;
      step(8);
      look(cSh | bLs | bOn | bStR);
      sensePins = 3'h0;
      mode = auxreg_pkg::MODE_FAILSAFE;
      step(4);
      look(cSh | bLs | bStR);
      close_out();
   end
endmodule : auxreg_ctrl_tb_top
